// [design/gpio_pkg.sv]
package gpio_pkg;
    localparam int FIRST_W = 6;
    localparam int SECOND_W = 8;
    localparam int CHANGE_W = 4;
    localparam int CHANGE_LO = 4;
    localparam int ADDR_W = 12;

    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_FIRST_DATA = 8'h05;
    localparam logic [7:0] IDX_SECOND_DATA = 8'h06;
    localparam logic [7:0] IDX_INT_CTRL = 8'h0b;
    localparam logic [7:0] IDX_OPTION = 8'h81;
    localparam logic [7:0] IDX_FIRST_DIR = 8'h85;
    localparam logic [7:0] IDX_SECOND_DIR = 8'h86;
    localparam logic [7:0] IDX_CMP_CTRL = 8'h9c;
    localparam logic [7:0] IDX_CMP_REF = 8'h9d;
    localparam logic [7:0] IDX_ANALOG_CFG = 8'h9f;
    localparam logic [7:0] IDX_PROG_CFG = 8'ha1;

    localparam logic [7:0] RST_OPTION = 8'hff;
    localparam logic [5:0] RST_FIRST_DIR = 6'h3f;
    localparam logic [7:0] RST_SECOND_DIR = 8'hff;
    localparam logic [5:0] RST_CMP_CTRL = 6'h07;
    localparam logic [7:0] RST_CMP_REF = 8'h00;
    localparam logic [7:0] RST_ANALOG_CFG = 8'h00;
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic RST_LVP = 1'b1;

    localparam int OPT_PULLUP_DIS = 7;
    localparam int OPT_EDGE_SEL = 6;
    localparam int ICTL_CHANGE = 0;
    localparam int ICTL_EXT = 1;
    localparam int PROG_LVP = 0;
    localparam int PIN_EXT_IRQ = 0;
    localparam int PIN_LVP = 3;
    localparam int PIN_OPEN_DRAIN = 4;
    localparam int PIN_SLAVE_SEL = 5;
    localparam int PIN_PROG_CLK = 6;
    localparam int PIN_PROG_DATA = 7;

    localparam logic [2:0] CMP_MODE_OUTPUTS = 3'h3;
    localparam logic [3:0] PCFG_DIGITAL_A = 4'h6;
    localparam logic [3:0] PCFG_DIGITAL_B = 4'h7;
    localparam logic [5:0] ANALOG_CAPABLE = 6'h2f;
    localparam logic [7:0] CMP_REF_WMASK = 8'hef;
    localparam logic [7:0] ANALOG_WMASK = 8'hcf;

    function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction : reg_addr
endpackage : gpio_pkg

// [design/pin_sync.sv]
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 14
) (
    input wire logic clk, // System clock
    input wire logic [W-1:0] din, // Asynchronous pin levels
    output logic [W-1:0] dout // Synchronised levels
);
    import gpio_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;

    sync_t sync_reg;
    sync_t sync_next;

    if (W < 1) begin : g_chk
        $error("pin_sync width must be at least one");
    end

    always_comb begin
        sync_next.s1 = din;
        sync_next.s2 = sync_reg.s1;
    end

    // No reset: chain holds true pin levels when reset ends
    always_ff @(posedge clk) begin
        sync_reg <= sync_next;
    end

    assign dout = sync_reg.s2;
endmodule : pin_sync

// [design/change_detect.sv]
`timescale 1ns/10ps
module change_detect #(
    parameter int GW = 4
) (
    input wire logic clk, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic [GW-1:0] pins, // Synchronised group levels
    input wire logic [GW-1:0] inputs_en, // Pins configured as inputs
    input wire logic refresh, // Port read or write
    output logic mismatch // Any input differs from snapshot
);
    import gpio_pkg::*;

    typedef struct packed {
        logic armed;
        logic [GW-1:0] snapshot;
    } cd_t;

    cd_t cd_reg;
    cd_t cd_next;

    if (GW < 1) begin : g_chk
        $error("change_detect group width must be at least one");
    end

    always_comb begin
        cd_next = cd_reg;
        if (refresh) begin
            cd_next.snapshot = pins;
            cd_next.armed = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cd_reg <= '0;
        end else begin
            cd_reg <= cd_next;
        end
    end

    // Outputs are excluded; nothing compares before the first access
    assign mismatch = cd_reg.armed & (|((pins ^ cd_reg.snapshot) & inputs_en));
endmodule : change_detect

// [design/gpio_ports_ab.sv]
`timescale 1ns/10ps
module gpio_ports_ab (
    input wire logic CLK_SYS, // 20 MHz system clock
    input wire logic SRST, // Synchronous reset, active high
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB access phase
    input wire logic PWRITE, // APB direction
    input wire logic [gpio_pkg::ADDR_W-1:0] PADDR, // APB byte address
    input wire logic [31:0] PWDATA, // APB write data
    output logic PREADY, // APB ready
    output logic [31:0] PRDATA, // APB read data
    output logic PSLVERR, // APB error, unmapped address
    input wire logic [gpio_pkg::FIRST_W-1:0] FIRST_PORT_IN, // First-port pin levels
    output logic [gpio_pkg::FIRST_W-1:0] FIRST_PORT_OUT, // First-port pin drive value
    output logic [gpio_pkg::FIRST_W-1:0] FIRST_PORT_OE, // First-port drive enable
    input wire logic [gpio_pkg::SECOND_W-1:0] SECOND_PORT_IN, // Second-port pin levels
    output logic [gpio_pkg::SECOND_W-1:0] SECOND_PORT_OUT, // Second-port drive value
    output logic [gpio_pkg::SECOND_W-1:0] SECOND_PORT_OE, // Second-port drive enable
    output logic [gpio_pkg::SECOND_W-1:0] SECOND_PORT_PULLUP, // Weak pull-up enables
    input wire logic COMPARATOR_ONE_OUTPUT, // Comparator one result
    input wire logic COMPARATOR_TWO_OUTPUT, // Comparator two result
    output logic TIMER_EXT_CLOCK_IN, // Timer external clock from pin
    output logic SLAVE_SELECT_N, // Serial slave select from pin
    output logic LOW_VOLTAGE_PROG_PIN, // Programming-mode pin level
    output logic SERIAL_PROG_CLOCK, // Programming clock from pin
    output logic SERIAL_PROG_DATA, // Programming data from pin
    output logic WAKE_REQUEST // Port change wakes from Sleep
);
    import gpio_pkg::*;

    typedef struct packed {
        logic [7:0] option;
        logic [FIRST_W-1:0] dir_a;
        logic [SECOND_W-1:0] dir_b;
        logic [FIRST_W-1:0] lat_a;
        logic [SECOND_W-1:0] lat_b;
        logic [5:0] cmp_ctrl;
        logic [7:0] cmp_ref;
        logic [7:0] analog_cfg;
        logic low_voltage_programming;
        logic change_flag;
        logic ext_flag;
        logic pb0_prev;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic [FIRST_W-1:0] pa_out;
        logic [FIRST_W-1:0] pa_oe;
        logic [SECOND_W-1:0] pb_out;
        logic [SECOND_W-1:0] pb_oe;
        logic [SECOND_W-1:0] pb_pullup;
        logic timer_clk;
        logic ss_n;
        logic prog_mode;
        logic prog_clk;
        logic prog_data;
        logic wake;
    } state_t;

    state_t state_reg;
    state_t state_next;

    logic [FIRST_W+SECOND_W-1:0] pins_sync;
    logic [FIRST_W-1:0] sync_a;
    logic [SECOND_W-1:0] sync_b;
    logic mismatch;
    logic setup;
    logic access;
    logic touch_b;
    logic ext_edge;
    logic [FIRST_W-1:0] dig_a;
    logic [FIRST_W-1:0] drv_a;
    logic cmp_pins;
    logic mapped;
    logic [7:0] rd_byte;
    logic [7:0] wbyte;

    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        return addr == reg_addr(idx);
    endfunction : hit

    function automatic logic [FIRST_W-1:0] digital_mask(input logic [3:0] pcfg);
        if (pcfg == PCFG_DIGITAL_A || pcfg == PCFG_DIGITAL_B) begin
            return '1;
        end
        return ~ANALOG_CAPABLE;
    endfunction : digital_mask

    pin_sync #(
        .W(FIRST_W + SECOND_W)
    ) u_sync (
        .clk(CLK_SYS),
        .din({SECOND_PORT_IN, FIRST_PORT_IN}),
        .dout(pins_sync)
    );

    assign sync_a = pins_sync[FIRST_W-1:0];
    assign sync_b = pins_sync[FIRST_W+SECOND_W-1:FIRST_W];

    change_detect #(
        .GW(CHANGE_W)
    ) u_change (
        .clk(CLK_SYS),
        .srst(SRST),
        .pins(sync_b[CHANGE_LO+CHANGE_W-1:CHANGE_LO]),
        .inputs_en(state_reg.dir_b[CHANGE_LO+CHANGE_W-1:CHANGE_LO]),
        .refresh(touch_b),
        .mismatch(mismatch)
    );

    always_comb begin
        setup = PSEL & ~PENABLE;
        access = PSEL & PENABLE & state_reg.pready;
        wbyte = PWDATA[7:0];
        touch_b = setup & hit(PADDR, IDX_SECOND_DATA);
        dig_a = digital_mask(state_reg.analog_cfg[3:0]);
        cmp_pins = state_reg.cmp_ctrl[2:0] == CMP_MODE_OUTPUTS;
        ext_edge = state_reg.option[OPT_EDGE_SEL]
            ? (sync_b[PIN_EXT_IRQ] & ~state_reg.pb0_prev)
            : (~sync_b[PIN_EXT_IRQ] & state_reg.pb0_prev);
        mapped = hit(PADDR, IDX_FIRST_DATA) | hit(PADDR, IDX_SECOND_DATA)
            | hit(PADDR, IDX_INT_CTRL) | hit(PADDR, IDX_OPTION)
            | hit(PADDR, IDX_FIRST_DIR) | hit(PADDR, IDX_SECOND_DIR)
            | hit(PADDR, IDX_CMP_CTRL) | hit(PADDR, IDX_CMP_REF)
            | hit(PADDR, IDX_ANALOG_CFG) | hit(PADDR, IDX_PROG_CFG);

        // Read value: data registers return pin levels; analog-selected pins and the enabled LVP pin read zero
        rd_byte = 8'h00;
        if (hit(PADDR, IDX_FIRST_DATA)) begin
            rd_byte = {2'h0, sync_a & dig_a};
        end else if (hit(PADDR, IDX_SECOND_DATA)) begin
            rd_byte = sync_b;
            rd_byte[PIN_LVP] = sync_b[PIN_LVP] & ~state_reg.low_voltage_programming;
        end else if (hit(PADDR, IDX_INT_CTRL)) begin
            rd_byte = {6'h00, state_reg.ext_flag, state_reg.change_flag};
        end else if (hit(PADDR, IDX_OPTION)) begin
            rd_byte = state_reg.option;
        end else if (hit(PADDR, IDX_FIRST_DIR)) begin
            rd_byte = {2'h0, state_reg.dir_a};
        end else if (hit(PADDR, IDX_SECOND_DIR)) begin
            rd_byte = state_reg.dir_b;
        end else if (hit(PADDR, IDX_CMP_CTRL)) begin
            rd_byte = {COMPARATOR_TWO_OUTPUT, COMPARATOR_ONE_OUTPUT, state_reg.cmp_ctrl};
        end else if (hit(PADDR, IDX_CMP_REF)) begin
            rd_byte = state_reg.cmp_ref;
        end else if (hit(PADDR, IDX_ANALOG_CFG)) begin
            rd_byte = state_reg.analog_cfg;
        end else if (hit(PADDR, IDX_PROG_CFG)) begin
            rd_byte = {7'h00, state_reg.low_voltage_programming};
        end

        state_next = state_reg;

        // APB: answer registered in the setup cycle, one access cycle
        state_next.pready = setup;
        state_next.pslverr = setup & ~mapped;
        if (setup) begin
            state_next.prdata = PWRITE ? 32'h0 : {24'h0, rd_byte};
        end

        // Writes take effect at the access edge
        if (access & PWRITE & ~state_reg.pslverr) begin
            if (hit(PADDR, IDX_FIRST_DATA)) begin
                state_next.lat_a = wbyte[FIRST_W-1:0];
            end
            if (hit(PADDR, IDX_SECOND_DATA)) begin
                state_next.lat_b = wbyte;
            end
            if (hit(PADDR, IDX_OPTION)) begin
                state_next.option = wbyte;
            end
            if (hit(PADDR, IDX_FIRST_DIR)) begin
                state_next.dir_a = wbyte[FIRST_W-1:0];
            end
            if (hit(PADDR, IDX_SECOND_DIR)) begin
                state_next.dir_b = wbyte;
            end
            if (hit(PADDR, IDX_CMP_CTRL)) begin
                state_next.cmp_ctrl = wbyte[5:0];
            end
            if (hit(PADDR, IDX_CMP_REF)) begin
                state_next.cmp_ref = wbyte & CMP_REF_WMASK;
            end
            if (hit(PADDR, IDX_ANALOG_CFG)) begin
                state_next.analog_cfg = wbyte & ANALOG_WMASK;
            end
            if (hit(PADDR, IDX_PROG_CFG)) begin
                state_next.low_voltage_programming = wbyte[PROG_LVP];
            end
            if (hit(PADDR, IDX_INT_CTRL)) begin
                state_next.change_flag = state_reg.change_flag & wbyte[ICTL_CHANGE];
                state_next.ext_flag = state_reg.ext_flag & wbyte[ICTL_EXT];
            end
        end

        // Hardware set wins over a clear in the same cycle
        if (mismatch) begin
            state_next.change_flag = 1'b1;
        end
        state_next.pb0_prev = sync_b[PIN_EXT_IRQ];
        if (ext_edge) begin
            state_next.ext_flag = 1'b1;
        end
        state_next.wake = state_next.change_flag;

        // First port drive; bit 4 pulls low only
        drv_a = state_reg.lat_a;
        if (cmp_pins) begin
            drv_a[PIN_OPEN_DRAIN] = COMPARATOR_ONE_OUTPUT;
            drv_a[PIN_SLAVE_SEL] = COMPARATOR_TWO_OUTPUT;
        end
        state_next.pa_out = drv_a;
        state_next.pa_oe = ~state_reg.dir_a & dig_a;
        if (cmp_pins) begin
            state_next.pa_oe[PIN_SLAVE_SEL] = ~state_reg.dir_a[PIN_SLAVE_SEL];
        end
        state_next.pa_out[PIN_OPEN_DRAIN] = 1'b0;
        state_next.pa_oe[PIN_OPEN_DRAIN] = ~state_reg.dir_a[PIN_OPEN_DRAIN]
            & ~drv_a[PIN_OPEN_DRAIN];

        // Second port drive and pull-ups
        state_next.pb_out = state_reg.lat_b;
        state_next.pb_oe = ~state_reg.dir_b;
        if (state_reg.low_voltage_programming) begin
            state_next.pb_oe[PIN_LVP] = 1'b0;
        end
        state_next.pb_pullup = state_reg.dir_b
            & {SECOND_W{~state_reg.option[OPT_PULLUP_DIS]}};

        // Alternate input functions
        state_next.timer_clk = sync_a[PIN_OPEN_DRAIN];
        state_next.ss_n = sync_a[PIN_SLAVE_SEL];
        state_next.prog_mode = state_reg.low_voltage_programming & sync_b[PIN_LVP];
        state_next.prog_clk = sync_b[PIN_PROG_CLK];
        state_next.prog_data = sync_b[PIN_PROG_DATA];
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            state_reg <= '0;
            state_reg.option <= RST_OPTION;
            state_reg.dir_a <= RST_FIRST_DIR;
            state_reg.dir_b <= RST_SECOND_DIR;
            state_reg.lat_a <= RST_LATCH[FIRST_W-1:0];
            state_reg.lat_b <= RST_LATCH;
            state_reg.cmp_ctrl <= RST_CMP_CTRL;
            state_reg.cmp_ref <= RST_CMP_REF;
            state_reg.analog_cfg <= RST_ANALOG_CFG;
            state_reg.low_voltage_programming <= RST_LVP;
            // Edge history starts at the pin level, so no false edge
            state_reg.pb0_prev <= sync_b[PIN_EXT_IRQ];
            state_reg.timer_clk <= 1'b0;
            state_reg.ss_n <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign PREADY = state_reg.pready;
    assign PRDATA = state_reg.prdata;
    assign PSLVERR = state_reg.pslverr;
    assign FIRST_PORT_OUT = state_reg.pa_out;
    assign FIRST_PORT_OE = state_reg.pa_oe;
    assign SECOND_PORT_OUT = state_reg.pb_out;
    assign SECOND_PORT_OE = state_reg.pb_oe;
    assign SECOND_PORT_PULLUP = state_reg.pb_pullup;
    assign TIMER_EXT_CLOCK_IN = state_reg.timer_clk;
    assign SLAVE_SELECT_N = state_reg.ss_n;
    assign LOW_VOLTAGE_PROG_PIN = state_reg.prog_mode;
    assign SERIAL_PROG_CLOCK = state_reg.prog_clk;
    assign SERIAL_PROG_DATA = state_reg.prog_data;
    assign WAKE_REQUEST = state_reg.wake;

    sequence apb_setup_s;
        PSEL && !PENABLE;
    endsequence

    sequence second_touch_s;
        touch_b ##1 $stable(sync_b[CHANGE_LO+CHANGE_W-1:CHANGE_LO]);
    endsequence

    apb_answer_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        apb_setup_s |=> PREADY)
        else $error("no ready one cycle after setup");

    pullup_output_off_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        1'b1 |=> (SECOND_PORT_PULLUP & ~$past(state_reg.dir_b)) == 8'h00)
        else $error("pull-up active on an output pin");

    pullup_global_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        !state_reg.option[OPT_PULLUP_DIS] |=>
            SECOND_PORT_PULLUP == $past(state_reg.dir_b))
        else $error("pull-ups not following global control");

    drive_latch_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        !state_reg.low_voltage_programming |=> SECOND_PORT_OE == ~$past(state_reg.dir_b)
            && SECOND_PORT_OUT == $past(state_reg.lat_b))
        else $error("second port not driving its latch");

    change_flag_set_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        mismatch |=> state_reg.change_flag && WAKE_REQUEST)
        else $error("mismatch did not set the change flag");

    snapshot_refresh_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        second_touch_s |-> !mismatch)
        else $error("port access did not end the mismatch");

    ext_edge_flag_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        ext_edge |=> state_reg.ext_flag)
        else $error("external edge not flagged");

    open_drain_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        FIRST_PORT_OE[PIN_OPEN_DRAIN] |-> !FIRST_PORT_OUT[PIN_OPEN_DRAIN])
        else $error("open-drain bit driven high");

    lvp_pin_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        state_reg.low_voltage_programming ##1 state_reg.low_voltage_programming |-> !SECOND_PORT_OE[PIN_LVP])
        else $error("programming pin driven while enabled");

    first_upper_zero_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        access && !PWRITE && (hit(PADDR, IDX_FIRST_DATA) || hit(PADDR, IDX_FIRST_DIR))
            |-> PRDATA[7:FIRST_W] == 2'h0)
        else $error("unused first-port bits read non-zero");
endmodule : gpio_ports_ab

// [verif/gpio_ports_ab_test.sv]
`timescale 1ns/10ps
module gpio_ports_ab_test;
    import gpio_pkg::*;

    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] a_in = 6'h00;
    logic [5:0] a_out;
    logic [5:0] a_oe;
    logic [7:0] b_in = 8'h00;
    logic [7:0] b_out;
    logic [7:0] b_oe;
    logic [7:0] b_pu;
    logic tmr_clk;
    logic ss_n;
    logic lvp_pin;
    logic pg_clk;
    logic pg_dat;
    logic wake;
    logic cmp_one = 1'b0;
    logic cmp_two = 1'b0;
    logic [31:0] rd;
    logic err;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    logic [7:0] ridx [8] = '{IDX_OPTION, IDX_FIRST_DIR, IDX_SECOND_DIR, IDX_CMP_CTRL,
        IDX_CMP_REF, IDX_ANALOG_CFG, IDX_INT_CTRL, IDX_PROG_CFG};
    logic [7:0] rexp [8] = '{8'hff, 8'h3f, 8'hff, 8'h07, 8'h00, 8'h00, 8'h00, 8'h01};
    logic [7:0] widx [5] = '{IDX_OPTION, IDX_FIRST_DIR, IDX_SECOND_DIR, IDX_CMP_REF,
        IDX_ANALOG_CFG};
    logic [7:0] wdat [5] = '{8'h3c, 8'hff, 8'h5a, 8'hff, 8'hff};
    logic [7:0] wexp [5] = '{8'h3c, 8'h3f, 8'h5a, 8'hef, 8'hcf};

    always #25 clk = ~clk;

    gpio_ports_ab u_gpio_ports_ab (
        .CLK_SYS(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
        .PSLVERR(pslverr), .FIRST_PORT_IN(a_in), .FIRST_PORT_OUT(a_out),
        .FIRST_PORT_OE(a_oe), .SECOND_PORT_IN(b_in), .SECOND_PORT_OUT(b_out),
        .SECOND_PORT_OE(b_oe), .SECOND_PORT_PULLUP(b_pu), .COMPARATOR_ONE_OUTPUT(cmp_one),
        .COMPARATOR_TWO_OUTPUT(cmp_two), .TIMER_EXT_CLOCK_IN(tmr_clk),
        .SLAVE_SELECT_N(ss_n), .LOW_VOLTAGE_PROG_PIN(lvp_pin),
        .SERIAL_PROG_CLOCK(pg_clk), .SERIAL_PROG_DATA(pg_dat), .WAKE_REQUEST(wake)
    );

    task wrap_up;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            $display("wrong value at %0t: run did not finish", $time);
            wrap_up;
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // One APB transfer; request held until ready is seen, released at that edge
    task xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task wr(input logic [7:0] idx, input logic [7:0] wd);
        xfer(1'b1, idx, wd);
    endtask : wr

    task rdc(input logic [7:0] idx, input logic [7:0] exp, input string what);
        xfer(1'b0, idx, 8'h00);
        check(rd, {24'h0, exp}, what);
    endtask : rdc

    task settle;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task pins(input logic [5:0] a, input logic [7:0] b);
        @(posedge clk);
        a_in <= a;
        b_in <= b;
        settle;
    endtask : pins

    task do_reset;
        @(posedge clk);
        srst <= 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        settle;
    endtask : do_reset

    initial begin
        do_reset;
        check(b_pu, 8'h00, "pull-ups after reset");
        check(b_oe, 8'h00, "second drive after reset");
        for (int i = 0; i < 8; i++) rdc(ridx[i], rexp[i], "reset value");
        for (int i = 0; i < 5; i++) begin
            wr(widx[i], wdat[i]);
            rdc(widx[i], wexp[i], "readback");
        end
        xfer(1'b0, 8'h10, 8'h00);
        check({rd[31:1], err}, 32'h1, "unmapped read");
        wr(8'h10, 8'hff);
        check({31'h0, err}, 32'h1, "unmapped write");
        $display("test registers done");

        do_reset;
        wr(IDX_PROG_CFG, 8'h00);
        wr(IDX_SECOND_DATA, 8'ha5);
        wr(IDX_SECOND_DIR, 8'h00);
        wr(IDX_OPTION, 8'h7f);
        settle;
        check(b_oe, 8'hff, "all outputs");
        check(b_out, 8'ha5, "latch on pins");
        check(b_pu, 8'h00, "no pull-up on outputs");
        wr(IDX_PROG_CFG, 8'h01);
        settle;
        check(b_oe, 8'hf7, "programming pin not driven");
        wr(IDX_SECOND_DIR, 8'h0f);
        settle;
        check(b_oe, 8'hf0, "inputs float");
        check(b_pu, 8'h0f, "pull-ups on inputs");
        wr(IDX_OPTION, 8'hff);
        settle;
        check(b_pu, 8'h00, "pull-ups disabled");
        wr(IDX_SECOND_DATA, 8'h3c);
        pins(6'h00, 8'hc8);
        rdc(IDX_SECOND_DATA, 8'hc0, "pin levels read");
        check(b_out & b_oe, 8'h30, "write hits latch");
        check(lvp_pin, 1'b1, "programming pin");
        check({pg_dat, pg_clk}, 2'b11, "programming clock and data");
        $display("test second_port done");

        do_reset;
        pins(6'h00, 8'h00);
        rdc(IDX_SECOND_DATA, 8'h00, "arm snapshot");
        pins(6'h00, 8'h20);
        check(wake, 1'b1, "wake on change");
        rdc(IDX_INT_CTRL, 8'h01, "change flag");
        wr(IDX_INT_CTRL, 8'h00);
        rdc(IDX_INT_CTRL, 8'h01, "flag held by mismatch");
        rdc(IDX_SECOND_DATA, 8'h20, "refresh snapshot");
        wr(IDX_INT_CTRL, 8'h00);
        rdc(IDX_INT_CTRL, 8'h00, "flag cleared");
        settle;
        check(wake, 1'b0, "wake dropped");
        pins(6'h00, 8'h2e);
        rdc(IDX_INT_CTRL, 8'h00, "lower pins ignored");
        wr(IDX_SECOND_DIR, 8'h7f);
        pins(6'h00, 8'hae);
        rdc(IDX_INT_CTRL, 8'h00, "output pin ignored");
        wr(IDX_OPTION, 8'hc0);
        pins(6'h00, 8'haf);
        rdc(IDX_INT_CTRL, 8'h02, "rising edge");
        wr(IDX_INT_CTRL, 8'h00);
        wr(IDX_OPTION, 8'h80);
        pins(6'h00, 8'hae);
        rdc(IDX_INT_CTRL, 8'h02, "falling edge");
        $display("test change_detect done");

        pins(6'h3f, 8'h01);
        do_reset;
        rdc(IDX_INT_CTRL, 8'h00, "no edge after reset");
        pins(6'h3f, 8'h00);
        rdc(IDX_FIRST_DATA, 8'h10, "analog pins read zero");
        check({tmr_clk, ss_n}, 2'b11, "timer clock and slave select");
        wr(IDX_ANALOG_CFG, 8'h06);
        rdc(IDX_FIRST_DATA, 8'h3f, "digital pins");
        wr(IDX_FIRST_DATA, 8'hff);
        wr(IDX_FIRST_DIR, 8'h00);
        settle;
        check(a_oe, 6'h2f, "open drain released high");
        check(a_out, 6'h2f, "open drain never drives high");
        wr(IDX_FIRST_DATA, 8'h00);
        settle;
        check(a_oe, 6'h3f, "open drain pulls low");
        wr(IDX_CMP_CTRL, 8'h03);
        @(posedge clk);
        cmp_two <= 1'b1;
        settle;
        check(a_out, 6'h20, "comparator two on bit 5");
        check(a_oe, 6'h3f, "comparator one low pulls bit 4");
        @(posedge clk);
        cmp_one <= 1'b1;
        cmp_two <= 1'b0;
        settle;
        check(a_out, 6'h00, "comparator two low on bit 5");
        check(a_oe, 6'h2f, "comparator one high releases bit 4");
        rdc(IDX_CMP_CTRL, 8'h43, "comparator results read");
        pins(6'h0f, 8'h00);
        check({tmr_clk, ss_n}, 2'b00, "alternate inputs low");
        $display("test first_port done");
        wrap_up;
    end
endmodule : gpio_ports_ab_test
